// File: hdl/rgate_pkg.sv
// Constants, register map and types of the release gate block
// Operation
// - Manual restart: raise rearm request, not release
// - Automatic restart: release follows evaluation directly
// - Minimum pulse high selectable 1/100/350 ms
// - 1 ms setting checks no minimum length
// - Restart ignored once release already confirmed
// - Only full low-high-low pulse is valid
// - Restart under bypass enters regular operation
// - Mute rising edge holds, falling edge releases
// - Mute holds only releases already high
// - Mute input not debounced
// - Optional mute time limit up to 7200 s
// - Mute needs edge; high at start ignored
// - Mute acts on all releases equally
// - Bypass rising edge forces releases 1-4 high
// - Bypass falling edge returns to evaluation
// - Bypass input not debounced
// - Optional bypass time limit up to 600 min
// - Bypass needs edge; acts on all equally
// - Sensor fault or warning option drops releases
// - Error clears automatically or by reset pulse
// - Consolidation only with dual channel inputs
// - Consolidate as in1, in2, max, min, average
package rgate_pkg;
	localparam int NREL = 4;
	localparam int VALW = 16;
	localparam int CLK_HZ = 100000000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = TICK_US * (CLK_HZ / 1000000);
	localparam int PULSE_MAX_MS = 30000;
	localparam int PULSE_MIN_A_MS = 1;
	localparam int PULSE_MIN_B_MS = 100;
	localparam int PULSE_MIN_C_MS = 350;
	localparam int MUTE_MAX_S = 7200;
	localparam int BYP_MAX_MIN = 600;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MUTE_LIM = 8'h04;
	localparam logic [7:0] ADDR_BYP_LIM = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_CONS = 8'h10;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] MUTE_LIM_RESET = 32'h0000_0001;
	localparam logic [31:0] BYP_LIM_RESET = 32'h0000_0001;
	localparam int CTRL_MANUAL = 0;
	localparam int CTRL_USE_RESET = 1;
	localparam int CTRL_MUTE_EN = 2;
	localparam int CTRL_MUTE_LIM = 3;
	localparam int CTRL_BYP_EN = 4;
	localparam int CTRL_BYP_LIM = 5;
	localparam int CTRL_WARN_DIS = 6;
	localparam int CTRL_DEB_LO = 7;
	localparam int CTRL_DUAL = 9;
	localparam int CTRL_CONS_LO = 10;
	typedef enum logic [1:0] {DEB_1MS, DEB_100MS, DEB_350MS, DEB_RSVD} rgate_deb_t;
	typedef enum logic [2:0] {CONS_IN1, CONS_IN2, CONS_MAX, CONS_MIN, CONS_AVG} rgate_cons_t;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : rgate_pkg

// File: hdl/rgate_release_gate.sv
// Release gating with restart interlock, mute, bypass and error handling
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
module rgate_release_gate (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Operator and evaluation inputs
	input wire logic restartIn,
	input wire logic errResetIn,
	input wire logic muteIn,
	input wire logic bypassIn,
	input wire logic [rgate_pkg::NREL-1:0] evalRelease,
	input wire logic sensorFault,
	input wire logic rangeWarn,
	input wire logic [rgate_pkg::VALW-1:0] value1,
	input wire logic [rgate_pkg::VALW-1:0] value2,
	// Outputs
	output logic [rgate_pkg::NREL-1:0] releaseOut,
	output logic restartReq,
	output logic resetReq,
	output logic muteActive,
	output logic bypassActive,
	output logic errorActive,
	output logic [rgate_pkg::VALW-1:0] consValue,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	function automatic logic [31:0] ms2ticks(input int ms);
		ms2ticks = 32'(ms);
	endfunction : ms2ticks

	logic [31:0] ctrl_reg;
	logic [31:0] muteLim_reg;
	logic [31:0] bypLim_reg;
	logic [7:0] awAddr_reg;
	logic awHave_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic wHave_reg;
	logic [16:0] tickCnt_reg;
	logic tick;
	logic primed_reg;
	logic restartPrev_reg;
	logic errRstPrev_reg;
	logic mutePrev_reg;
	logic bypPrev_reg;
	logic [31:0] rstPulse_reg;
	logic [31:0] errPulse_reg;
	logic restartValid;
	logic errRstValid;
	logic [31:0] minTicks;
	logic confirmed_reg;
	logic [rgate_pkg::NREL-1:0] held_reg;
	logic [31:0] muteCnt_reg;
	logic [31:0] bypCnt_reg;
	logic errLatch_reg;
	logic errCause;
	logic manual;
	logic evalAny;
	logic [rgate_pkg::NREL-1:0] gated;
	logic [31:0] statusWord;
	logic [16:0] sumVal;

	assign manual = ctrl_reg[rgate_pkg::CTRL_MANUAL];

	// AXI4-Lite write: address and data taken in either order
	assign s_axi_awready = !awHave_reg && !s_axi_bvalid;
	assign s_axi_wready = !wHave_reg && !s_axi_bvalid;
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			awHave_reg <= 1'b0;
			wHave_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= rgate_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHave_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHave_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (awHave_reg && wHave_reg)
			begin
				awHave_reg <= 1'b0;
				wHave_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (awAddr_reg)
					rgate_pkg::ADDR_CTRL, rgate_pkg::ADDR_MUTE_LIM, rgate_pkg::ADDR_BYP_LIM:
						s_axi_bresp <= rgate_pkg::RESP_OKAY;
					default:
						s_axi_bresp <= rgate_pkg::RESP_SLVERR;
				endcase
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	function automatic logic [31:0] strobe(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (st[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		strobe = r;
	endfunction : strobe

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			ctrl_reg <= rgate_pkg::CTRL_RESET;
			muteLim_reg <= rgate_pkg::MUTE_LIM_RESET;
			bypLim_reg <= rgate_pkg::BYP_LIM_RESET;
		end
		else if (awHave_reg && wHave_reg)
		begin
			case (awAddr_reg)
				rgate_pkg::ADDR_CTRL:
					ctrl_reg <= strobe(ctrl_reg, wData_reg, wStrb_reg);
				rgate_pkg::ADDR_MUTE_LIM:
					muteLim_reg <= strobe(muteLim_reg, wData_reg, wStrb_reg);
				rgate_pkg::ADDR_BYP_LIM:
					bypLim_reg <= strobe(bypLim_reg, wData_reg, wStrb_reg);
				default:
					ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	// AXI4-Lite read, one cycle answer
	assign s_axi_arready = !s_axi_rvalid;
	assign statusWord = {24'h000000, errorActive, resetReq, bypassActive, muteActive,
		restartReq, |releaseOut, confirmed_reg, errCause};
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= rgate_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= rgate_pkg::RESP_OKAY;
			case (s_axi_araddr)
				rgate_pkg::ADDR_CTRL: s_axi_rdata <= ctrl_reg;
				rgate_pkg::ADDR_MUTE_LIM: s_axi_rdata <= muteLim_reg;
				rgate_pkg::ADDR_BYP_LIM: s_axi_rdata <= bypLim_reg;
				rgate_pkg::ADDR_STATUS: s_axi_rdata <= statusWord;
				rgate_pkg::ADDR_CONS: s_axi_rdata <= {16'h0000, consValue};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= rgate_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Millisecond tick; pulse lengths are measured in whole ticks
	assign tick = (tickCnt_reg == 17'(rgate_pkg::TICK_CYC - 1));
	always_ff @(posedge clk)
	begin
		if (!rstn || tick)
			tickCnt_reg <= 17'h00000;
		else
			tickCnt_reg <= tickCnt_reg + 17'h00001;
	end

	// Edge detection against previous sample; primed blocks start-up edges
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			primed_reg <= 1'b0;
			restartPrev_reg <= 1'b0;
			errRstPrev_reg <= 1'b0;
			mutePrev_reg <= 1'b0;
			bypPrev_reg <= 1'b0;
		end
		else
		begin
			primed_reg <= 1'b1;
			restartPrev_reg <= restartIn;
			errRstPrev_reg <= errResetIn;
			mutePrev_reg <= muteIn;
			bypPrev_reg <= bypassIn;
		end
	end

	always_comb
	begin
		case (rgate_pkg::rgate_deb_t'(ctrl_reg[rgate_pkg::CTRL_DEB_LO +: 2]))
			rgate_pkg::DEB_100MS: minTicks = ms2ticks(rgate_pkg::PULSE_MIN_B_MS);
			rgate_pkg::DEB_350MS: minTicks = ms2ticks(rgate_pkg::PULSE_MIN_C_MS);
			default: minTicks = 32'h0000_0000;
		endcase
	end

	// High-phase counters; counting starts only from a seen low level
	function automatic logic [31:0] pulseCnt(input logic [31:0] cnt, input logic lvl,
		input logic prev, input logic tk);
		if (!lvl)
			pulseCnt = 32'h0000_0000;
		else if (!prev)
			pulseCnt = 32'h0000_0001;
		else if (cnt != 32'h0000_0000 && tk && cnt <= ms2ticks(rgate_pkg::PULSE_MAX_MS))
			pulseCnt = cnt + 32'h0000_0001;
		else
			pulseCnt = cnt;
	endfunction : pulseCnt

	// Valid on falling edge: within min and max length, begun after start-up
	function automatic logic pulseOk(input logic [31:0] cnt, input logic lvl, input logic prev,
		input logic [31:0] mn);
		pulseOk = prev && !lvl && cnt != 32'h0000_0000 && (cnt - 32'h0000_0001) >= mn
			&& cnt <= ms2ticks(rgate_pkg::PULSE_MAX_MS);
	endfunction : pulseOk

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			rstPulse_reg <= 32'h0000_0000;
			errPulse_reg <= 32'h0000_0000;
		end
		else if (primed_reg)
		begin
			rstPulse_reg <= pulseCnt(rstPulse_reg, restartIn, restartPrev_reg, tick);
			errPulse_reg <= pulseCnt(errPulse_reg, errResetIn, errRstPrev_reg, tick);
		end
	end
	assign restartValid = primed_reg && pulseOk(rstPulse_reg, restartIn, restartPrev_reg, minTicks);
	assign errRstValid = primed_reg && pulseOk(errPulse_reg, errResetIn, errRstPrev_reg, minTicks);

	// Error latch; manual reset needs cause gone plus valid pulse
	assign errCause = sensorFault || (rangeWarn && ctrl_reg[rgate_pkg::CTRL_WARN_DIS]);
	always_ff @(posedge clk)
	begin
		if (!rstn)
			errLatch_reg <= 1'b0;
		else if (errCause)
			errLatch_reg <= 1'b1;
		else if (!ctrl_reg[rgate_pkg::CTRL_USE_RESET] || errRstValid)
			errLatch_reg <= 1'b0;
	end
	assign errorActive = errLatch_reg;
	assign resetReq = errLatch_reg && !errCause && ctrl_reg[rgate_pkg::CTRL_USE_RESET];

	// Restart interlock
	assign evalAny = |evalRelease;
	always_ff @(posedge clk)
	begin
		if (!rstn)
			confirmed_reg <= 1'b0;
		else if (!manual)
			confirmed_reg <= 1'b0;
		else if (errLatch_reg || (!evalAny && !bypassActive))
			confirmed_reg <= 1'b0;
		else if (restartValid && !confirmed_reg)
			confirmed_reg <= 1'b1;
	end
	assign restartReq = manual && !confirmed_reg && !errLatch_reg && evalAny;

	// Muting: hold only releases high at the rising edge, with optional limit
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			muteActive <= 1'b0;
			muteCnt_reg <= 32'h0000_0000;
		end
		else if (!ctrl_reg[rgate_pkg::CTRL_MUTE_EN] || !muteIn)
		begin
			muteActive <= 1'b0;
			muteCnt_reg <= 32'h0000_0000;
		end
		else if (primed_reg && !mutePrev_reg)
		begin
			muteActive <= 1'b1;
			muteCnt_reg <= 32'h0000_0000;
		end
		else if (muteActive && tick)
		begin
			muteCnt_reg <= muteCnt_reg + 32'h0000_0001;
			if (ctrl_reg[rgate_pkg::CTRL_MUTE_LIM] && muteCnt_reg + 32'h0000_0001 >=
				muteLim_reg * 32'd1000)
				muteActive <= 1'b0;
		end
	end
	always_ff @(posedge clk)
	begin
		if (!rstn)
			held_reg <= '0;
		else if (muteIn && !mutePrev_reg && primed_reg)
			held_reg <= releaseOut;
		else if (!muteActive)
			held_reg <= '0;
	end

	// Bypass with optional limit in minutes
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			bypassActive <= 1'b0;
			bypCnt_reg <= 32'h0000_0000;
		end
		else if (!ctrl_reg[rgate_pkg::CTRL_BYP_EN] || !bypassIn)
		begin
			bypassActive <= 1'b0;
			bypCnt_reg <= 32'h0000_0000;
		end
		else if (primed_reg && !bypPrev_reg)
		begin
			bypassActive <= 1'b1;
			bypCnt_reg <= 32'h0000_0000;
		end
		else if (bypassActive && tick)
		begin
			bypCnt_reg <= bypCnt_reg + 32'h0000_0001;
			if (ctrl_reg[rgate_pkg::CTRL_BYP_LIM] && bypCnt_reg + 32'h0000_0001 >=
				bypLim_reg * 32'd60000)
				bypassActive <= 1'b0;
		end
	end

	// Release composition; error overrides everything, mute and bypass act on all bits
	always_comb
	begin
		gated = manual ? (confirmed_reg ? evalRelease : '0) : evalRelease;
		if (bypassActive)
			gated = '1;
		gated = gated | (muteActive ? held_reg : '0);
		if (errLatch_reg)
			gated = '0;
	end
	always_ff @(posedge clk)
	begin
		if (!rstn)
			releaseOut <= '0;
		else
			releaseOut <= gated;
	end

	// Consolidation, only when dual channel configured
	assign sumVal = {1'b0, value1} + {1'b0, value2};
	always_ff @(posedge clk)
	begin
		if (!rstn)
			consValue <= '0;
		else if (!ctrl_reg[rgate_pkg::CTRL_DUAL])
			consValue <= value1;
		else
		begin
			case (rgate_pkg::rgate_cons_t'(ctrl_reg[rgate_pkg::CTRL_CONS_LO +: 3]))
				rgate_pkg::CONS_IN2: consValue <= value2;
				rgate_pkg::CONS_MAX: consValue <= (value1 > value2) ? value1 : value2;
				rgate_pkg::CONS_MIN: consValue <= (value1 < value2) ? value1 : value2;
				rgate_pkg::CONS_AVG: consValue <= sumVal[16:1];
				default: consValue <= value1;
			endcase
		end
	end
endmodule : rgate_release_gate

// File: testbench/rgate_release_gate_checker.sv
// Port checker of the release gate
module rgate_release_gate_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Operator levels and gate outputs
	input wire logic muteIn,
	input wire logic bypassIn,
	input wire logic [rgate_pkg::NREL-1:0] releaseOut,
	input wire logic muteActive,
	input wire logic bypassActive,
	input wire logic errorActive,
	// Bus responses
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	b_hold_a:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	r_hold_a:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	rd_answer_a:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	err_drop_a:
		assert property (errorActive && !bypassActive && !bypassIn |=> releaseOut == 4'h0)
		else $error("release high under error");
	byp_force_a:
		assert property (bypassActive && !errorActive
			|=> releaseOut == 4'hf || !bypassActive || errorActive)
		else $error("release not forced by bypass");
	mute_start_a:
		assert property ($rose(muteActive) |-> $past(muteIn))
		else $error("mute started without input");
	mute_end_a:
		assert property ($fell(muteIn) |-> ##[0:2] !muteActive)
		else $error("mute did not end");
	byp_end_a:
		assert property ($fell(bypassIn) |-> ##[0:2] !bypassActive)
		else $error("bypass did not end");
endmodule : rgate_release_gate_checker

bind rgate_release_gate rgate_release_gate_checker chk_i (
	.clk(clk),
	.rstn(rstn),
	.muteIn(muteIn),
	.bypassIn(bypassIn),
	.releaseOut(releaseOut),
	.muteActive(muteActive),
	.bypassActive(bypassActive),
	.errorActive(errorActive),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata)
);

// File: testbench/rgate_operator.sv
// Operator model: restart and reset buttons, mute and bypass switches
module rgate_operator (
	// Clock
	input wire logic clk,
	// Operator outputs
	output logic restartIn,
	output logic errResetIn,
	output logic muteIn,
	output logic bypassIn
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		restartIn = 1'b0;
		errResetIn = 1'b0;
		muteIn = 1'b0;
		bypassIn = 1'b0;
	end
	// Whole low-high-low pulse, far below the 30 s ceiling
	task automatic press(input bit rst, input int len);
		@(posedge clk);
		if (rst)
			errResetIn <= 1'b1;
		else
			restartIn <= 1'b1;
		repeat (len) @(posedge clk);
		errResetIn <= 1'b0;
		restartIn <= 1'b0;
	endtask : press
	// Switch levels change only at an edge
	task automatic set_switch(input bit byp, input logic v);
		@(posedge clk);
		if (byp)
			bypassIn <= v;
		else
			muteIn <= v;
	endtask : set_switch
endmodule : rgate_operator

// File: testbench/testbench.sv
// Self-checking bench of the release gate
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic restartIn, errResetIn, muteIn, bypassIn;
	logic [3:0] evalRelease = 4'h0;
	logic sensorFault = 1'b0;
	logic rangeWarn = 1'b0;
	logic [15:0] value1 = 16'h0000;
	logic [15:0] value2 = 16'h0000;
	logic [3:0] relOut;
	logic restartReq, resetReq, muteActive, bypassActive, errorActive;
	logic [15:0] consValue;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int num_errors = 0;
	int checks = 0;
	always #5 clk = ~clk;
	rgate_operator op (.clk(clk), .restartIn(restartIn), .errResetIn(errResetIn),
		.muteIn(muteIn), .bypassIn(bypassIn));
	rgate_release_gate dut (.clk(clk), .rstn(rstn), .restartIn(restartIn),
		.errResetIn(errResetIn), .muteIn(muteIn), .bypassIn(bypassIn),
		.evalRelease(evalRelease), .sensorFault(sensorFault), .rangeWarn(rangeWarn),
		.value1(value1), .value2(value2), .releaseOut(relOut), .restartReq(restartReq),
		.resetReq(resetReq), .muteActive(muteActive), .bypassActive(bypassActive),
		.errorActive(errorActive), .consValue(consValue), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask : chk
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("write response", 32'h0, {30'h0, bresp});
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input bit err);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk("read data", d, rdata);
		chk("read response", {30'h0, err ? rgate_pkg::RESP_SLVERR : rgate_pkg::RESP_OKAY},
			{30'h0, rresp});
	endtask : axi_read
	task automatic ctrl(input logic [31:0] d);
		axi_write(rgate_pkg::ADDR_CTRL, d);
	endtask : ctrl
	task automatic wait_rel(input logic [3:0] exp);
		for (int i = 0; i < 10 && relOut !== exp; i++)
			@(posedge clk);
		chk("release", {28'h0, exp}, {28'h0, relOut});
	endtask : wait_rel
	task automatic hold_rel(input logic [3:0] exp);
		repeat (8) @(posedge clk);
		chk("release", {28'h0, exp}, {28'h0, relOut});
	endtask : hold_rel
	task automatic test_regs;
		axi_read(rgate_pkg::ADDR_CTRL, rgate_pkg::CTRL_RESET, 1'b0);
		axi_read(rgate_pkg::ADDR_MUTE_LIM, rgate_pkg::MUTE_LIM_RESET, 1'b0);
		axi_read(rgate_pkg::ADDR_BYP_LIM, rgate_pkg::BYP_LIM_RESET, 1'b0);
		axi_write(rgate_pkg::ADDR_MUTE_LIM, 32'h0000_1c20);
		axi_read(rgate_pkg::ADDR_MUTE_LIM, 32'h0000_1c20, 1'b0);
		axi_write(rgate_pkg::ADDR_BYP_LIM, 32'h0000_0258);
		axi_read(rgate_pkg::ADDR_BYP_LIM, 32'h0000_0258, 1'b0);
		axi_read(8'h20, 32'h0, 1'b1);
		$display("test regs done");
	endtask : test_regs
	task automatic test_auto;
		ctrl(32'h0);
		evalRelease <= 4'hf;
		wait_rel(4'hf);
		chk("restart request", 32'h0, {31'h0, restartReq});
		evalRelease <= 4'h0;
		wait_rel(4'h0);
		$display("test auto done");
	endtask : test_auto
	task automatic test_manual;
		ctrl(32'h81);
		evalRelease <= 4'hf;
		hold_rel(4'h0);
		chk("restart request", 32'h1, {31'h0, restartReq});
		op.press(1'b0, 3);
		hold_rel(4'h0);
		ctrl(32'h101);
		op.press(1'b0, 3);
		hold_rel(4'h0);
		ctrl(32'h1);
		op.press(1'b0, 3);
		wait_rel(4'hf);
		chk("restart request", 32'h0, {31'h0, restartReq});
		op.press(1'b0, 3);
		hold_rel(4'hf);
		$display("test manual done");
	endtask : test_manual
	task automatic test_bypass;
		evalRelease <= 4'h0;
		ctrl(32'h10);
		wait_rel(4'h0);
		op.set_switch(1'b1, 1'b1);
		wait_rel(4'hf);
		chk("bypass active", 32'h1, {31'h0, bypassActive});
		op.set_switch(1'b1, 1'b0);
		wait_rel(4'h0);
		ctrl(32'h11);
		evalRelease <= 4'hf;
		hold_rel(4'h0);
		op.set_switch(1'b1, 1'b1);
		wait_rel(4'hf);
		op.press(1'b0, 3);
		repeat (3) @(posedge clk);
		op.set_switch(1'b1, 1'b0);
		hold_rel(4'hf);
		$display("test bypass done");
	endtask : test_bypass
	task automatic test_mute;
		evalRelease <= 4'h3;
		ctrl(32'h04);
		wait_rel(4'h3);
		op.set_switch(1'b0, 1'b1);
		repeat (3) @(posedge clk);
		chk("mute active", 32'h1, {31'h0, muteActive});
		evalRelease <= 4'hf;
		wait_rel(4'hf);
		evalRelease <= 4'h0;
		hold_rel(4'h3);
		op.set_switch(1'b0, 1'b0);
		wait_rel(4'h0);
		$display("test mute done");
	endtask : test_mute
	task automatic test_error;
		evalRelease <= 4'hf;
		ctrl(32'h40);
		wait_rel(4'hf);
		sensorFault <= 1'b1;
		wait_rel(4'h0);
		chk("error active", 32'h1, {31'h0, errorActive});
		sensorFault <= 1'b0;
		wait_rel(4'hf);
		rangeWarn <= 1'b1;
		wait_rel(4'h0);
		rangeWarn <= 1'b0;
		wait_rel(4'hf);
		ctrl(32'h02);
		rangeWarn <= 1'b1;
		hold_rel(4'hf);
		sensorFault <= 1'b1;
		rangeWarn <= 1'b0;
		wait_rel(4'h0);
		sensorFault <= 1'b0;
		hold_rel(4'h0);
		chk("reset request", 32'h1, {31'h0, resetReq});
		op.press(1'b1, 3);
		wait_rel(4'hf);
		$display("test error done");
	endtask : test_error
	task automatic test_cons;
		logic [15:0] expv [5] = '{16'h000a, 16'h001e, 16'h001e, 16'h000a, 16'h0014};
		value1 <= 16'h000a;
		value2 <= 16'h001e;
		for (int k = 0; k < 5; k++)
		begin
			ctrl(32'h200 | (k << 10));
			repeat (3) @(posedge clk);
			chk("consolidated value", {16'h0, expv[k]}, {16'h0, consValue});
		end
		ctrl(32'h400);
		repeat (3) @(posedge clk);
		chk("consolidated value", 32'h000a, {16'h0, consValue});
		$display("test cons done");
	endtask : test_cons
	// Switches already high across a reset must not start mute or bypass
	task automatic test_startup;
		evalRelease <= 4'h0;
		op.set_switch(1'b0, 1'b1);
		op.set_switch(1'b1, 1'b1);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		chk("release in reset", 32'h0, {28'h0, relOut});
		rstn <= 1'b1;
		ctrl(32'h14);
		hold_rel(4'h0);
		chk("mute active", 32'h0, {31'h0, muteActive});
		chk("bypass active", 32'h0, {31'h0, bypassActive});
		op.set_switch(1'b0, 1'b0);
		op.set_switch(1'b1, 1'b0);
		$display("test startup done");
	endtask : test_startup
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		fork
		begin
			#200000;
			num_errors++;
			tally_and_finish();
		end
		join_none
		repeat (20) @(posedge clk);
		chk("release in reset", 32'h0, {28'h0, relOut});
		rstn <= 1'b1;
		test_regs();
		test_auto();
		test_manual();
		test_bypass();
		test_mute();
		test_error();
		test_cons();
		test_startup();
		tally_and_finish();
	end
endmodule : testbench
